// ---- src/dct_pkg.sv ----
// constants and register map of the converter channel 1 trigger and interrupt block
// Function
// RULE1 - trigger line select bits 6:4 pick line
// RULE2 - source bit 2: data write or trigger
// RULE3 - auto refresh bit 1 enables periodic refresh
// RULE4 - refresh interval comes from main control register
// RULE5 - enable bit 5 gates channel 1 underflow
// RULE6 - enable bit 4 gates channel 0 underflow
// RULE7 - enable bit 1 gates channel 1 completion
// RULE8 - enable bit 0 gates channel 0; resets zero
// RULE9 - software writes zero to reserved bits
// RULE10 - channel enable bit 0 allows any conversion
// RULE11 - interrupt high while enabled flag set
// RULE12 - flags at bits 5,4,1,0 gated by enables
// RULE13 - data valid set on write, cleared on use
package dct_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CH1_CTRL = 8'h0c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
	localparam logic [7:0] OFS_IRQ_SET = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
	localparam logic [7:0] OFS_CH0_DATA = 8'h20;
	localparam logic [7:0] OFS_CH1_DATA = 8'h24;
	localparam logic [7:0] OFS_COMB_DATA = 8'h28;
	// channel 1 control fields
	localparam int CH1_EN_BIT = 0;
	localparam int CH1_REFR_BIT = 1;
	localparam int CH1_SRC_BIT = 2;
	localparam int CH1_SEL_LSB = 4;
	localparam int CH1_SEL_W = 3;
	localparam logic [31:0] CH1_CTRL_MASK = 32'h0000_0077;
	localparam logic [31:0] CH1_CTRL_RST = 32'h0000_0000;
	// main control: refresh period select field
	localparam int REFR_SEL_LSB = 20;
	localparam int REFR_SEL_W = 2;
	localparam logic [31:0] MAIN_CTRL_MASK = 32'h0030_0000;
	localparam logic [31:0] MAIN_CTRL_RST = 32'h0000_0000;
	// interrupt flag / enable layout
	localparam int IRQ_CH0_DONE = 0;
	localparam int IRQ_CH1_DONE = 1;
	localparam int IRQ_CH0_UF = 4;
	localparam int IRQ_CH1_UF = 5;
	localparam logic [5:0] IRQ_MASK = 6'h33;
	localparam logic [5:0] IRQ_RST = 6'h00;
	// status bits
	localparam int STAT_CH0_DV = 0;
	localparam int STAT_CH1_DV = 1;
	// data word layout
	localparam int DATA_W = 12;
	localparam int COMB_CH1_LSB = 16;
	// bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// shortest refresh period in clock cycles, doubled per select step
	localparam int REFR_UNIT_CYC = 8;
endpackage : dct_pkg

// ---- src/dct_sync.sv ----
// two-stage synchroniser with rising edge detect for trigger lines
`timescale 1ns/1ps
module dct_sync import dct_pkg::*; #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// asynchronous lines in
	input wire logic [W-1:0] lines_in,
	// synchronised level and rising edge pulse out
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;

	// first flop feeds only the second; edges are taken after stage two
	always_ff @(posedge clock) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= lines_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~last_q;
endmodule : dct_sync

// ---- src/dct_top.sv ----
// converter channel 1 trigger control, refresh timer and interrupt logic with axi4-lite slave
`timescale 1ns/1ps
module dct_top import dct_pkg::*; #(
	parameter int LINES = 8,
	parameter int REFR_UNIT = REFR_UNIT_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// event trigger network lines, asynchronous
	input wire logic [LINES-1:0] trigger_lines,
	// channel 0 events from the converter core, same clock
	input wire logic chan0_conv_done_evt,
	input wire logic chan0_underflow_evt,
	input wire logic chan0_data_used,
	// channel 1 converter core side
	output logic chan1_conv_start,
	output logic [DATA_W-1:0] chan1_conv_data,
	output logic chan1_on,
	// interrupt request
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// elaboration checks, refused parameter values stop the build
	if (LINES != (1 << CH1_SEL_W)) $error("trigger line count must match select width");
	if (REFR_UNIT < 1) $error("refresh unit must be at least one cycle");

	localparam int REFR_MAX = REFR_UNIT << ((1 << REFR_SEL_W) - 1);
	localparam int RC_W = $clog2(REFR_MAX + 1);

	// merge new write data into a word under byte strobes and a field mask
	function automatic logic [31:0] merge_word(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] be;
		be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge_word = ((old_v & ~be) | (new_v & be)) & mask;
	endfunction : merge_word

	////////////////////////////////////////////////////////////////////////////
	// bus slave state

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q;
	logic w_have_q;

	wire aw_take = s_axi_awvalid & awready_q;
	wire w_take = s_axi_wvalid & wready_q;
	// a write is executed once both halves are held and no response is pending
	wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
	wire ar_take = s_axi_arvalid & arready_q;
	wire b_done = bvalid_q & s_axi_bready;
	wire r_done = rvalid_q & s_axi_rready;

	// write address and data latches, taken in either order
	always_ff @(posedge clock) begin
		if (!resetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (b_done) begin
				awready_q <= 1'b1;
				wready_q <= 1'b1;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
		end
	end

	// write address decode
	wire wr_main = do_wr & (waddr_q == OFS_MAIN_CTRL);
	wire wr_ch1c = do_wr & (waddr_q == OFS_CH1_CTRL);
	wire wr_ien = do_wr & (waddr_q == OFS_IRQ_EN);
	wire wr_ifs = do_wr & (waddr_q == OFS_IRQ_SET);
	wire wr_ifc = do_wr & (waddr_q == OFS_IRQ_CLR);
	wire wr_d0 = do_wr & (waddr_q == OFS_CH0_DATA);
	wire wr_d1 = do_wr & (waddr_q == OFS_CH1_DATA);
	wire wr_dc = do_wr & (waddr_q == OFS_COMB_DATA);
	wire wr_hit = wr_main | wr_ch1c | wr_ien | wr_ifs | wr_ifc | wr_d0 | wr_d1 | wr_dc;

	// write response, slave error for unmapped or read-only offsets
	always_ff @(posedge clock) begin
		if (!resetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (b_done) begin
			bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers

	logic [31:0] main_ctrl_q;
	logic [31:0] ch1_ctrl_q;
	logic [5:0] ien_q;
	logic [DATA_W-1:0] ch1_data_q;

	wire [DATA_W-1:0] comb_ch1 = DATA_W'(wdata_q >> COMB_CH1_LSB);
	wire [31:0] ien_wide = {26'h0, ien_q};
	wire [31:0] ien_merged = merge_word(ien_wide, wdata_q, wstrb_q, {26'h0, IRQ_MASK});

	// reserved bits are masked on write so they always read zero
	always_ff @(posedge clock) begin
		if (!resetn) begin
			main_ctrl_q <= MAIN_CTRL_RST;
			ch1_ctrl_q <= CH1_CTRL_RST; // RULE8
			ien_q <= IRQ_RST; // RULE8
			ch1_data_q <= '0;
		end else begin
			if (wr_main)
				main_ctrl_q <= merge_word(main_ctrl_q, wdata_q, wstrb_q, MAIN_CTRL_MASK);
			if (wr_ch1c)
				ch1_ctrl_q <= merge_word(ch1_ctrl_q, wdata_q, wstrb_q, CH1_CTRL_MASK); // RULE9
			if (wr_ien)
				ien_q <= ien_merged[5:0]; // RULE9
			if (wr_d1)
				ch1_data_q <= wdata_q[DATA_W-1:0];
			else if (wr_dc)
				ch1_data_q <= comb_ch1;
		end
	end

	// field views of channel 1 control
	wire ch1_en = ch1_ctrl_q[CH1_EN_BIT];
	wire ch1_refr = ch1_ctrl_q[CH1_REFR_BIT];
	wire ch1_src = ch1_ctrl_q[CH1_SRC_BIT];
	wire [CH1_SEL_W-1:0] ch1_sel = ch1_ctrl_q[CH1_SEL_LSB +: CH1_SEL_W];
	wire [REFR_SEL_W-1:0] refr_sel = main_ctrl_q[REFR_SEL_LSB +: REFR_SEL_W];

	////////////////////////////////////////////////////////////////////////////
	// trigger selection and conversion start

	logic [LINES-1:0] trig_rise;

	dct_sync #(
		.W(LINES)
	) u_sync (
		.clock(clock),
		.resetn(resetn),
		.lines_in(trigger_lines),
		.level(), // only edges start conversions
		.rise(trig_rise)
	);

	wire trig_hit = trig_rise[ch1_sel]; // RULE1
	wire data_start = ~ch1_src & (wr_d1 | wr_dc); // RULE2
	wire line_start = ch1_src & trig_hit; // RULE2
	wire new_start = ch1_en & (data_start | line_start); // RULE10

	// refresh timer; period doubles per select step, counted only while refresh runs
	logic [RC_W-1:0] refr_cnt_q;
	wire [31:0] refr_period = REFR_UNIT << refr_sel; // RULE4
	wire [RC_W-1:0] refr_last = RC_W'(refr_period - 1);
	wire refr_run = ch1_en & ch1_refr; // RULE3
	wire refr_tick = refr_run & (refr_cnt_q == refr_last); // RULE3

	always_ff @(posedge clock) begin
		if (!resetn)
			refr_cnt_q <= '0;
		else if (!refr_run | refr_tick | (refr_cnt_q > refr_last))
			refr_cnt_q <= '0;
		else
			refr_cnt_q <= refr_cnt_q + 1'b1;
	end

	// data valid flags; a write in the same cycle as a use keeps the flag set
	logic ch0_dv_q;
	logic ch1_dv_q;
	wire ch1_used = new_start & ch1_dv_q;
	wire ch1_uf = line_start & ch1_en & ~ch1_dv_q;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ch0_dv_q <= 1'b0;
			ch1_dv_q <= 1'b0;
		end else begin
			ch0_dv_q <= (wr_d0 | wr_dc) | (ch0_dv_q & ~chan0_data_used); // RULE13
			ch1_dv_q <= (wr_d1 | wr_dc) | (ch1_dv_q & ~ch1_used); // RULE13
		end
	end

	// value that is being written this cycle when the start is data-driven
	wire [DATA_W-1:0] ch1_data_next = wr_d1 ? wdata_q[DATA_W-1:0] : comb_ch1;
	// start pulse to the core; a refresh reconverts the held word without using new data
	logic start_q;
	logic [DATA_W-1:0] conv_data_q;
	logic on_q;
	logic done_q;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			start_q <= 1'b0;
			conv_data_q <= '0;
			on_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			start_q <= new_start | refr_tick; // RULE3
			if (new_start & (data_start | ch1_dv_q))
				conv_data_q <= data_start ? ch1_data_next : ch1_data_q[DATA_W-1:0];
			on_q <= ch1_en; // RULE10
			done_q <= start_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt flags, set wins over clear

	logic [5:0] flags_q;
	logic irq_q;
	logic [5:0] hw_set;
	wire [5:0] sw_set = wr_ifs ? (wdata_q[5:0] & IRQ_MASK) : 6'h00;
	wire [5:0] sw_clr = wr_ifc ? (wdata_q[5:0] & IRQ_MASK) : 6'h00;

	always_comb begin
		hw_set = 6'h00;
		hw_set[IRQ_CH0_DONE] = chan0_conv_done_evt; // RULE12
		hw_set[IRQ_CH1_DONE] = done_q; // RULE12
		hw_set[IRQ_CH0_UF] = chan0_underflow_evt; // RULE12
		hw_set[IRQ_CH1_UF] = ch1_uf; // RULE12
	end

	wire [5:0] flags_d = (flags_q & ~sw_clr) | hw_set | sw_set;
	wire [5:0] pending = flags_d & ien_q; // RULE5 RULE6 RULE7 RULE8

	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags_q <= IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq_q <= |pending; // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path

	wire rd_main = s_axi_araddr == OFS_MAIN_CTRL;
	wire rd_stat = s_axi_araddr == OFS_STATUS;
	wire rd_ch1c = s_axi_araddr == OFS_CH1_CTRL;
	wire rd_ien = s_axi_araddr == OFS_IRQ_EN;
	wire rd_flag = s_axi_araddr == OFS_IRQ_FLAG;
	wire rd_wo = (s_axi_araddr == OFS_IRQ_SET) | (s_axi_araddr == OFS_IRQ_CLR) |
		(s_axi_araddr == OFS_CH0_DATA) | (s_axi_araddr == OFS_CH1_DATA) |
		(s_axi_araddr == OFS_COMB_DATA);
	wire rd_hit = rd_main | rd_stat | rd_ch1c | rd_ien | rd_flag | rd_wo;
	wire [31:0] stat_word = {30'h0, ch1_dv_q, ch0_dv_q};
	// write-only offsets read as zero
	wire [31:0] rd_word = rd_main ? main_ctrl_q :
		rd_stat ? stat_word :
		rd_ch1c ? ch1_ctrl_q :
		rd_ien ? {26'h0, ien_q} :
		rd_flag ? {26'h0, flags_q} : 32'h0000_0000;

	// read data is captured at the address edge and held until taken
	always_ff @(posedge clock) begin
		if (!resetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_done) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign chan1_conv_start = start_q;
	assign chan1_conv_data = conv_data_q;
	assign chan1_on = on_q;
	assign irq = irq_q;
endmodule : dct_top

// ---- testbench/dct_monitor.sv ----
// port checker for the channel 1 trigger and interrupt block
`timescale 1ns/1ps
module dct_monitor import dct_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter side and interrupt
	input wire logic chan1_conv_start,
	input wire logic chan1_on,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////////
	// both halves of one write taken at the same edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// a write aimed at the read-only flag word
	sequence s_ro_write;
		s_wr_take ##0 (s_axi_awaddr == OFS_IRQ_FLAG);
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	a_ro_refused: assert property (s_ro_write |-> ##2 s_axi_bresp == RESP_SLVERR)
		else $error("flag word write not refused");
	a_aw_busy: assert property (s_wr_take |=> (!s_axi_awready && !s_axi_wready) [*2])
		else $error("write channel ready too early");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_reset_quiet: assert property ($rose(resetn) |-> !irq && !chan1_conv_start && !chan1_on)
		else $error("outputs active after reset");
	a_start_on: assert property (chan1_conv_start |-> chan1_on)
		else $error("start while channel off");
endmodule : dct_monitor

// ---- testbench/test_dct_top.sv ----
// self-checking bench for the channel 1 trigger and interrupt block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module test_dct_top;
	import dct_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] trigger_lines = 8'h00;
	logic chan0_conv_done_evt = 1'b0, chan0_underflow_evt = 1'b0, chan0_data_used = 1'b0;
	logic chan1_conv_start, chan1_on, irq;
	logic [DATA_W-1:0] chan1_conv_data;
	int n_fail = 0, num_checks = 0, k;
	// short refresh unit keeps the period counts small
	dct_top #(.LINES(8), .REFR_UNIT(2)) u_dut (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_lines, .chan0_conv_done_evt,
		.chan0_underflow_evt, .chan0_data_used, .chan1_conv_start, .chan1_conv_data,
		.chan1_on, .irq);
	always #4 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////////
	// bus write; bready comes late so the response has to stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			// bready drops at the handshake edge itself; the watchdog bounds the wait
			s_axi_bready <= (n >= 3) && !(s_axi_bvalid && s_axi_bready);
		end while (!(s_axi_bvalid && s_axi_bready));
		`CHK("bresp", e, s_axi_bresp)
	endtask : wr
	// bus read with a late rready, compared against the expected word
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			s_axi_rready <= (n >= 2) && !(s_axi_rvalid && s_axi_rready);
		end while (!(s_axi_rvalid && s_axi_rready));
		`CHK("rdata", e, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask : rd
	// count start pulses over a window of cycles
	task automatic starts(input int cyc, output int c);
		c = 0;
		repeat (cyc) begin
			@(posedge clock);
			if (chan1_conv_start === 1'b1) c++;
		end
	endtask : starts
	// raise one trigger line for four cycles while counting starts
	task automatic pulse(input int i, output int c);
		fork
			begin
				@(posedge clock);
				trigger_lines[i] <= 1'b1;
				repeat (4) @(posedge clock);
				trigger_lines[i] <= 1'b0;
			end
			starts(14, c);
		join
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(OFS_CH1_CTRL, 32'h0, RESP_OKAY);
		rd(OFS_IRQ_EN, 32'h0, RESP_OKAY);
		wr(OFS_CH1_CTRL, 32'h0000_0076, RESP_OKAY);
		rd(OFS_CH1_CTRL, 32'h76, RESP_OKAY);
		wr(OFS_IRQ_EN, 32'h0000_0033, RESP_OKAY);
		rd(OFS_IRQ_EN, 32'h33, RESP_OKAY);
		wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
		wr(OFS_CH1_CTRL, 32'h0, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(OFS_IRQ_FLAG, 32'h33, RESP_SLVERR);
		$display("register test done");
	endtask : t_regs
	// data-write starts, combined word, and no start while disabled
	task automatic t_data();
		wr(OFS_CH1_CTRL, 32'h1, RESP_OKAY);
		`CHK("on", 1'b1, chan1_on)
		fork wr(OFS_CH1_DATA, 32'habc, RESP_OKAY); starts(10, k); join
		`CHK("starts", 1, k)
		`CHK("data", 12'habc, chan1_conv_data)
		fork wr(OFS_COMB_DATA, 32'h0123_0456, RESP_OKAY); starts(10, k); join
		`CHK("data", 12'h123, chan1_conv_data)
		wr(OFS_CH1_CTRL, 32'h0, RESP_OKAY);
		`CHK("on", 1'b0, chan1_on)
		fork wr(OFS_CH1_DATA, 32'h111, RESP_OKAY); starts(10, k); join
		`CHK("starts", 0, k)
		$display("data test done");
	endtask : t_data
	// every trigger line: the selected one starts a conversion, its partner line s ^ 1 does not
	task automatic t_trig();
		for (int s = 0; s < 8; s++) begin
			wr(OFS_CH1_CTRL, 32'h5 | (s << 4), RESP_OKAY);
			pulse(s ^ 1, k);
			`CHK("starts", 0, k)
			pulse(s, k);
			`CHK("starts", 1, k)
		end
		// trigger mode: a data write only marks the word valid
		wr(OFS_CH1_DATA, 32'h5a5, RESP_OKAY);
		rd(OFS_STATUS, 32'h3, RESP_OKAY);
		pulse(7, k);
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		`CHK("data", 12'h5a5, chan1_conv_data)
		rd(OFS_IRQ_FLAG, 32'h22, RESP_OKAY);
		wr(OFS_CH1_CTRL, 32'h0, RESP_OKAY);
		$display("trigger test done");
	endtask : t_trig
	// each enable bit gates only its own flag
	task automatic t_irq();
		logic [31:0] b;
		for (int i = 0; i < 6; i++) begin
			if (IRQ_MASK[i]) begin
				b = 32'h1 << i;
				wr(OFS_IRQ_CLR, 32'h33, RESP_OKAY);
				wr(OFS_IRQ_EN, b, RESP_OKAY);
				wr(OFS_IRQ_SET, 32'h33 & ~b, RESP_OKAY);
				repeat (3) @(posedge clock);
				`CHK("irq", 1'b0, irq)
				wr(OFS_IRQ_SET, b, RESP_OKAY);
				repeat (3) @(posedge clock);
				`CHK("irq", 1'b1, irq)
				wr(OFS_IRQ_CLR, b, RESP_OKAY);
				repeat (3) @(posedge clock);
				`CHK("irq", 1'b0, irq)
			end
		end
		wr(OFS_IRQ_CLR, 32'h33, RESP_OKAY);
		@(posedge clock);
		chan0_conv_done_evt <= 1'b1;
		chan0_underflow_evt <= 1'b1;
		chan0_data_used <= 1'b1;
		@(posedge clock);
		chan0_conv_done_evt <= 1'b0;
		chan0_underflow_evt <= 1'b0;
		chan0_data_used <= 1'b0;
		rd(OFS_IRQ_FLAG, 32'h11, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
		$display("interrupt test done");
	endtask : t_irq
	// refresh period follows the main control select, off when bit 1 clear
	task automatic t_refr();
		wr(OFS_MAIN_CTRL, 32'h0, RESP_OKAY);
		wr(OFS_CH1_CTRL, 32'h3, RESP_OKAY);
		repeat (8) @(posedge clock);
		starts(40, k);
		`CHK("refresh", 20, k)
		wr(OFS_MAIN_CTRL, 32'h0010_0000, RESP_OKAY);
		repeat (8) @(posedge clock);
		starts(40, k);
		`CHK("refresh", 10, k)
		wr(OFS_CH1_CTRL, 32'h1, RESP_OKAY);
		starts(40, k);
		`CHK("refresh", 0, k)
		$display("refresh test done");
	endtask : t_refr
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		`CHK("irq", 1'b0, irq)
		t_regs();
		t_data();
		t_trig();
		t_irq();
		t_refr();
		end_of_test();
	end
endmodule : test_dct_top
bind dct_top dct_monitor u_mon (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chan1_conv_start, .chan1_on, .irq);
